// ---- common/crc_pkg.sv ----
package crc_pkg;
  localparam int WORD_W = 16;
  localparam int SHIFT_DIV = 4;
  localparam int GAP_SHIFTS = 4;
  localparam logic [1:0] SEL_NORMAL = 2'h0;
  localparam logic [1:0] SEL_PLUS = 2'h1;
  localparam logic [1:0] SEL_MINUS = 2'h2;
  localparam logic [1:0] SEL_SECONDARY = 2'h3;
  localparam logic [4:0] COARSE_RST = 5'h09;
  localparam logic [5:0] TRIM_RST = 6'h01;
  localparam logic [5:0] RATE_RST = 6'h24;
  localparam logic [5:0] RATE_FALLBACK = 6'h24;
  localparam logic [6:0] MOD64_ADD = 7'h40;
  localparam logic [7:0] CONFIG_RST = 8'hb9;
  // field positions in the secondary word
  localparam int TX_COARSE_LSB = 9;
  localparam int RX_COARSE_LSB = 2;
  localparam int TX_SIX_LSB = 9;
  localparam int RX_SIX_LSB = 2;
  // converter_config packs d9 into bit 7 and d7..d2 into bits 5..0, bit 6 is zero
  localparam int CFG_HPF = 0;
  localparam int CFG_LOOP = 1;
  localparam int CFG_AUX = 2;
  localparam int CFG_SYNC = 3;
  localparam int CFG_GAIN0 = 4;
  localparam int CFG_GAIN1 = 5;
  localparam int CFG_SINX = 7;
  typedef enum logic [2:0] {
    CRC_IDLE = 3'b000,
    CRC_SHIFT = 3'b001,
    CRC_GAP = 3'b011,
    CRC_SEC = 3'b010
  } crc_state_e;
endpackage

// ---- rtl/crc_codec_rate_config_serial.sv ----
`timescale 1ns/10ps
module crc_codec_rate_config_serial #(
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // serial link
  input wire logic host_to_unit_serial_word,
  output logic shift_clk,
  output logic tx_frame_sync_n,
  output logic rx_frame_sync_n,
  // converter side
  output logic [13:0] dac_sample,
  output logic dac_sample_valid,
  input wire logic dac_sample_ready,
  output logic dac_convert,
  output logic adc_convert,
  output logic [crc_pkg::WORD_W-9:0] converter_config,
  output logic shut_down
);
  import crc_pkg::*;

  // the buffer logic below serves exactly two entries
  if (BUF_DEPTH != 2) begin : g_depth_check
    $error("BUF_DEPTH must be 2");
  end

  // ------------------------------------------------------------
  // shift clock divider
  // ------------------------------------------------------------
  logic [1:0] div_q;
  logic sclk_rise, sclk_fall;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_q <= 2'h0;
      shift_clk <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      shift_clk <= (div_q == 2'h1) || (div_q == 2'h2);
    end
  end
  assign sclk_rise = (div_q == 2'h1);
  assign sclk_fall = (div_q == 2'h3);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [4:0] tx_coarse_divider_q, rx_coarse_divider_q;
  logic [5:0] tx_period_trim_q, rx_period_trim_q;
  logic [5:0] tx_rate_divider_q, rx_rate_divider_q;
  logic [4:0] rx_coarse_pend_q;
  logic [5:0] rx_trim_pend_q, rx_rate_pend_q;
  logic [2:0] rx_pend_q; // coarse, trim, rate pending
  logic [1:0] tx_adj_q, rx_adj_q;
  logic rx_adj_pend_q;

  // ------------------------------------------------------------
  // serial receiver
  // ------------------------------------------------------------
  crc_state_e state_q;
  logic [3:0] bit_q;
  logic [2:0] gap_q;
  logic [15:0] shreg_q;
  logic word_done, is_secondary_q, tx_period_end, rx_period_end;
  logic frame_req_q;
  logic [15:0] word;
  assign word = {shreg_q[14:0], host_to_unit_serial_word};
  assign word_done = (state_q == CRC_SHIFT) && sclk_fall && (bit_q == 4'hf);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= CRC_IDLE;
      bit_q <= 4'h0;
      gap_q <= 3'h0;
      shreg_q <= 16'h0000;
      is_secondary_q <= 1'b0;
      frame_req_q <= 1'b0;
      tx_frame_sync_n <= 1'b1;
      rx_frame_sync_n <= 1'b1;
    end else begin
      // a period end that misses a shift rise waits here for the next one
      if (tx_period_end) frame_req_q <= 1'b1;
      case (state_q)
        CRC_IDLE: begin
          if ((frame_req_q || tx_period_end) && sclk_rise) begin
            state_q <= CRC_SHIFT;
            is_secondary_q <= 1'b0;
            frame_req_q <= 1'b0;
            tx_frame_sync_n <= 1'b0;
            rx_frame_sync_n <= 1'b0;
            bit_q <= 4'h0;
          end else if (sclk_rise) begin
            // frame sync rises one shift clock after the last bit
            tx_frame_sync_n <= 1'b1;
            rx_frame_sync_n <= 1'b1;
          end
        end
        CRC_SHIFT: begin
          if (sclk_fall) begin
            shreg_q <= word;
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'hf) begin
              if (!is_secondary_q && word[1:0] == SEL_SECONDARY) begin
                state_q <= CRC_GAP;
                gap_q <= 3'h0;
              end else begin
                state_q <= CRC_IDLE;
              end
            end
          end
        end
        CRC_GAP: begin
          if (sclk_rise) begin
            if (gap_q == 3'(GAP_SHIFTS)) begin
              state_q <= CRC_SHIFT;
              is_secondary_q <= 1'b1;
              tx_frame_sync_n <= 1'b0;
              rx_frame_sync_n <= converter_config[CFG_SYNC];
              bit_q <= 4'h0;
            end else begin
              // first rise ends the primary frame, three more make the gap
              tx_frame_sync_n <= 1'b1;
              rx_frame_sync_n <= 1'b1;
              gap_q <= gap_q + 3'h1;
            end
          end
        end
        default: state_q <= CRC_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // register writes from the secondary word
  // ------------------------------------------------------------
  logic sec_done, pri_done;
  assign sec_done = word_done && is_secondary_q;
  assign pri_done = word_done && !is_secondary_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_coarse_divider_q <= COARSE_RST;
      tx_period_trim_q <= TRIM_RST;
      tx_rate_divider_q <= RATE_RST;
      converter_config <= CONFIG_RST;
    end else if (sec_done) begin
      case (word[1:0])
        2'h0: tx_coarse_divider_q <= word[TX_COARSE_LSB +: 5];
        2'h1: tx_period_trim_q <= word[TX_SIX_LSB +: 6];
        2'h2: begin
          if (word[TX_SIX_LSB +: 6] < 6'h02) begin
            tx_rate_divider_q <= RATE_FALLBACK;
          end else begin
            tx_rate_divider_q <= word[TX_SIX_LSB +: 6];
          end
        end
        default: converter_config <= {word[9], 1'b0, word[7:2]};
      endcase
    end
  end

  // rx values wait in pending slots until the rx period ends
  logic rx_sec_wr;
  assign rx_sec_wr = sec_done && (word[1:0] != SEL_SECONDARY);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_coarse_pend_q <= COARSE_RST;
      rx_trim_pend_q <= TRIM_RST;
      rx_rate_pend_q <= RATE_RST;
      rx_pend_q <= 3'h0;
    end else begin
      if (rx_period_end) rx_pend_q <= 3'h0;
      // a write landing on the period end is kept for the next period
      if (rx_sec_wr && (rx_period_end || !rx_pend_q[word[1:0]])) begin
        rx_pend_q[word[1:0]] <= 1'b1;
        case (word[1:0])
          2'h0: rx_coarse_pend_q <= word[RX_COARSE_LSB +: 5];
          2'h1: rx_trim_pend_q <= word[RX_SIX_LSB +: 6];
          default: rx_rate_pend_q <= (word[RX_SIX_LSB +: 6] < 6'h02) ? RATE_FALLBACK
                                     : word[RX_SIX_LSB +: 6];
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_coarse_divider_q <= COARSE_RST;
      rx_period_trim_q <= TRIM_RST;
      rx_rate_divider_q <= RATE_RST;
    end else if (rx_period_end) begin
      if (rx_pend_q[0]) rx_coarse_divider_q <= rx_coarse_pend_q;
      if (rx_pend_q[1]) rx_period_trim_q <= rx_trim_pend_q;
      if (rx_pend_q[2]) rx_rate_divider_q <= rx_rate_pend_q;
    end
  end

  // ------------------------------------------------------------
  // adjust commands
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_adj_q <= SEL_NORMAL;
      rx_adj_q <= SEL_NORMAL;
      rx_adj_pend_q <= 1'b0;
    end else begin
      if (pri_done) begin
        tx_adj_q <= (word[1:0] == SEL_SECONDARY) ? SEL_NORMAL : word[1:0];
      end else if (tx_period_end) begin
        tx_adj_q <= SEL_NORMAL;
      end
      if (pri_done && !rx_adj_pend_q && (word[1:0] == SEL_PLUS || word[1:0] == SEL_MINUS)) begin
        rx_adj_q <= word[1:0];
        rx_adj_pend_q <= 1'b1;
      end else if (rx_period_end) begin
        rx_adj_q <= SEL_NORMAL;
        rx_adj_pend_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // counter A load value with fallbacks
  // ------------------------------------------------------------
  function automatic logic [5:0] crc_load_a(input logic [4:0] coarse, input logic [5:0] trim,
                                            input logic [1:0] sel);
    logic signed [7:0] sum;
    sum = 8'sh00;
    case (sel)
      SEL_PLUS: sum = $signed({3'h0, coarse}) + $signed({{2{trim[5]}}, trim});
      SEL_MINUS: sum = $signed({3'h0, coarse}) - $signed({{2{trim[5]}}, trim});
      default: sum = $signed({3'h0, coarse});
    endcase
    if (sum < 0) begin
      crc_load_a = 6'(sum + $signed({1'b0, MOD64_ADD}));
    end else if (sum < 2) begin
      crc_load_a = {1'b0, coarse};
    end else begin
      crc_load_a = sum[5:0];
    end
  endfunction

  // ------------------------------------------------------------
  // conversion timing counters
  // ------------------------------------------------------------
  logic [6:0] tx_cnt_a_q, rx_cnt_a_q;
  logic [5:0] tx_cnt_b_q, rx_cnt_b_q;
  logic tx_a_end, rx_a_end, sync_mode, halt;
  assign sync_mode = converter_config[CFG_SYNC];
  assign halt = (tx_coarse_divider_q < 5'h02) ||
                (!sync_mode && rx_coarse_divider_q < 5'h02);
  // A counts two master clocks per count: filter clock is master / 2A
  assign tx_a_end = (tx_cnt_a_q <= 7'h01);
  assign rx_a_end = (rx_cnt_a_q <= 7'h01);
  assign tx_period_end = !halt && tx_a_end && (tx_cnt_b_q <= 6'h01);
  assign rx_period_end = sync_mode ? tx_period_end
                         : (!halt && rx_a_end && (rx_cnt_b_q <= 6'h01));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_cnt_a_q <= {COARSE_RST, 2'h0};
      tx_cnt_b_q <= RATE_RST;
    end else if (!halt) begin
      if (tx_a_end) begin
        tx_cnt_a_q <= {crc_load_a(tx_coarse_divider_q, tx_period_trim_q, tx_period_end ? tx_adj_q
                       : SEL_NORMAL), 1'b0};
        tx_cnt_b_q <= tx_period_end ? tx_rate_divider_q : tx_cnt_b_q - 6'h01;
      end else begin
        tx_cnt_a_q <= tx_cnt_a_q - 7'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_cnt_a_q <= {COARSE_RST, 2'h0};
      rx_cnt_b_q <= RATE_RST;
    end else if (!halt && !sync_mode) begin
      if (rx_a_end) begin
        rx_cnt_a_q <= {crc_load_a(rx_coarse_divider_q, rx_period_trim_q, rx_period_end ? rx_adj_q
                       : SEL_NORMAL), 1'b0};
        rx_cnt_b_q <= rx_period_end ? rx_rate_divider_q : rx_cnt_b_q - 6'h01;
      end else begin
        rx_cnt_a_q <= rx_cnt_a_q - 7'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dac_convert <= 1'b0;
      adc_convert <= 1'b0;
      shut_down <= 1'b0;
    end else begin
      dac_convert <= tx_period_end;
      adc_convert <= rx_period_end;
      shut_down <= halt;
    end
  end

  // ------------------------------------------------------------
  // two-entry sample buffer toward the converter
  // ------------------------------------------------------------
  logic [13:0] buf_q [BUF_DEPTH];
  logic [1:0] cnt_q;
  logic rd_q, wr_q, push, pop;
  assign pop = dac_sample_valid && dac_sample_ready;
  assign push = pri_done && (cnt_q != 2'(BUF_DEPTH)); // full buffer drops new word
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= 2'h0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      buf_q[0] <= 14'h0000;
      buf_q[1] <= 14'h0000;
      dac_sample <= 14'h0000;
      dac_sample_valid <= 1'b0;
    end else begin
      if (push) begin
        buf_q[wr_q] <= word[15:2];
        wr_q <= ~wr_q;
      end
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
      // dac_sample keeps last word when nothing new arrives
      if (!dac_sample_valid || pop) begin
        if (cnt_q - 2'(pop) != 2'h0) begin
          dac_sample <= buf_q[rd_q ^ pop];
          dac_sample_valid <= 1'b1;
        end else begin
          dac_sample_valid <= 1'b0;
        end
      end
    end
  end
endmodule

// ---- verif/crc_codec_monitor.sv ----
`timescale 1ns/10ps
module crc_codec_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // serial link
  input wire logic shift_clk,
  input wire logic tx_frame_sync_n,
  input wire logic rx_frame_sync_n,
  // converter side
  input wire logic [13:0] dac_sample,
  input wire logic dac_sample_valid,
  input wire logic dac_sample_ready,
  input wire logic dac_convert,
  input wire logic adc_convert,
  input wire logic [crc_pkg::WORD_W-9:0] converter_config,
  input wire logic shut_down
);
  import crc_pkg::*;
  logic [11:0] lo_cnt_q;
  logic [11:0] hi_cnt_q;
  logic sec_q;
  // --------------------------------
  // frame sync run lengths
  // --------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lo_cnt_q <= 12'h000;
      hi_cnt_q <= 12'hfff;
    end else begin
      lo_cnt_q <= tx_frame_sync_n ? 12'h000 : lo_cnt_q + 12'h001;
      hi_cnt_q <= !tx_frame_sync_n ? 12'h000 : hi_cnt_q + {11'h000, hi_cnt_q != 12'hfff};
    end
  end
  // marks a frame that follows the short gap
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sec_q <= 1'b0;
    end else begin
      sec_q <= !tx_frame_sync_n && (sec_q || hi_cnt_q == 12'h010);
    end
  end
  // --------------------------------
  // properties
  // --------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_shift_period: assert property ($rose(shift_clk) |-> ##4 $rose(shift_clk))
    else $error("shift clock period wrong");
  a_shift_duty: assert property ($rose(shift_clk) |=> shift_clk ##1 !shift_clk)
    else $error("shift clock high time wrong");
  a_frame_length: assert property ($rose(tx_frame_sync_n) |-> lo_cnt_q == 12'h040)
    else $error("frame sync low time wrong");
  a_second_gap: assert property ($fell(tx_frame_sync_n) && hi_cnt_q < 12'h040 |-> hi_cnt_q == 12'h010)
    else $error("gap before follow-up word wrong");
  a_rx_quiet: assert property ($rose(sec_q) && converter_config[CFG_SYNC] |-> rx_frame_sync_n [*8])
    else $error("receive sync during follow-up word");
  a_cfg_source: assert property (!$past(rst) && $changed(converter_config)
    |-> $past(sec_q) || $past(sec_q, 2) || $past(sec_q, 3))
    else $error("config changed outside follow-up word");
  a_stall_hold: assert property (dac_sample_valid && !dac_sample_ready
    |=> dac_sample_valid && $stable(dac_sample))
    else $error("sample lost during stall");
  a_sample_source: assert property (!$past(rst) && $changed(dac_sample)
    |-> $past(dac_sample_valid && dac_sample_ready) || !$past(dac_sample_valid))
    else $error("held sample changed");
  a_shut_quiet: assert property (shut_down |-> !dac_convert && !adc_convert)
    else $error("conversion while shut down");
  a_conv_pulse: assert property (dac_convert |=> !dac_convert)
    else $error("conversion pulse too long");
endmodule

// ---- verif/crc_codec_rate_config_serial_tb.sv ----
`timescale 1ns/10ps
module crc_codec_rate_config_serial_tb;
  import crc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic host_to_unit_serial_word;
  logic shift_clk, tx_frame_sync_n, rx_frame_sync_n, dac_sample_valid, dac_convert, adc_convert, shut_down;
  logic dac_sample_ready = 1'b0;
  logic [13:0] dac_sample;
  logic [7:0] converter_config;
  logic stall = 1'b1;
  logic [13:0] last_exp = 14'h0000;
  logic [7:0] c;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int t_dac = 0;
  int t_adc = 0;
  int per = 0;
  int aper = 0;
  always #25 clk_sys = ~clk_sys;
  crc_codec_rate_config_serial dut (.clk_sys(clk_sys), .rst(rst),
    .host_to_unit_serial_word(host_to_unit_serial_word), .shift_clk(shift_clk),
    .tx_frame_sync_n(tx_frame_sync_n), .rx_frame_sync_n(rx_frame_sync_n), .dac_sample(dac_sample),
    .dac_sample_valid(dac_sample_valid), .dac_sample_ready(dac_sample_ready), .dac_convert(dac_convert),
    .adc_convert(adc_convert), .converter_config(converter_config), .shut_down(shut_down));
  crc_host_model host (.shift_clk(shift_clk), .tx_frame_sync_n(tx_frame_sync_n),
    .serial_out(host_to_unit_serial_word));
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic send(input logic keep, input logic [15:0] sec);
    @(posedge tx_frame_sync_n);
    host.push({keep ? host.last_pri[15:2] : 14'($urandom), 2'b11});
    host.push(sec);
    repeat (2) @(posedge tx_frame_sync_n);
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic wait_conv(input int n);
    repeat (n) @(posedge clk_sys iff dac_convert);
    #1;
  endtask
  // --------------------------------
  // converter side: stalls, periods, sample scoreboard
  // --------------------------------
  always @(posedge clk_sys) begin
    cyc++;
    dac_sample_ready <= stall ? 1'b0 : 1'($urandom % 2);
    if (!rst && dac_convert) begin
      per = cyc - t_dac;
      t_dac = cyc;
    end
    if (!rst && adc_convert) begin
      aper = cyc - t_adc;
      t_adc = cyc;
    end
    if (!rst && dac_sample_valid && dac_sample_ready) begin
      if (host.exp_q.size() > 0) last_exp = host.exp_q.pop_front();
      check("dac_sample", 16'(dac_sample), 16'(last_exp));
    end
  end
  initial begin
    repeat (95000) @(posedge clk_sys);
    n_fail++;
    stop_test();
  end
  initial begin
    void'($urandom(99));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    stall <= 1'b0;
    wait_conv(3);
    check("period", 16'(per), 16'h0288);
    check("config", 16'(converter_config), 16'h00b9);
    check("shut_down", 16'(shut_down), 16'h0000);
    for (int i = 0; i < 6; i++) begin
      @(posedge tx_frame_sync_n);
      host.push({14'($urandom), 2'(i % 3)});
    end
    for (int i = 0; i < 3; i++) begin
      c = 8'($urandom) & 8'hb7;
      send(1'b0, {6'h00, c[7], 1'b0, c[5:0], 2'b11});
      check("config", 16'(converter_config), 16'(c));
    end
    // host keeps legal dividers and a period below 19.2 kHz here
    send(1'b0, {2'b00, 5'h0f, 2'b00, 5'h09, 2'b00});
    wait_conv(3);
    check("period", 16'(per), 16'h0438);
    send(1'b0, {1'b0, 6'h28, 1'b0, 6'h24, 2'b10});
    wait_conv(3);
    check("period", 16'(per), 16'h04b0);
    check("rx period", 16'(aper), 16'h0288);
    send(1'b0, {1'b0, 6'h01, 1'b0, 6'h01, 2'b10});
    wait_conv(3);
    check("period", 16'(per), 16'h0438);
    send(1'b0, {6'h00, 1'b1, 1'b0, 6'h1d, 2'b11});
    send(1'b0, {6'h00, 1'b1, 1'b0, 6'h1d, 2'b11});
    check("config", 16'(converter_config), 16'h009d);
    wait_conv(3);
    check("rx period", 16'(aper), 16'h0438);
    stall <= 1'b1;
    repeat (2) @(posedge tx_frame_sync_n);
    stall <= 1'b0;
    repeat (2) @(posedge tx_frame_sync_n);
    send(1'b1, {2'b00, 5'h01, 2'b00, 5'h09, 2'b00});
    check("shut_down", 16'(shut_down), 16'h0001);
    rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("config", 16'(converter_config), 16'h00b9);
    check("shut_down", 16'(shut_down), 16'h0000);
    wait_conv(3);
    check("period", 16'(per), 16'h0288);
    stop_test();
  end
endmodule
bind crc_codec_rate_config_serial crc_codec_monitor mon (.clk_sys(clk_sys), .rst(rst), .shift_clk(shift_clk),
  .tx_frame_sync_n(tx_frame_sync_n), .rx_frame_sync_n(rx_frame_sync_n), .dac_sample(dac_sample),
  .dac_sample_valid(dac_sample_valid), .dac_sample_ready(dac_sample_ready), .dac_convert(dac_convert),
  .adc_convert(adc_convert), .converter_config(converter_config), .shut_down(shut_down));

// ---- verif/crc_host_model.sv ----
`timescale 1ns/10ps
module crc_host_model (
  // from the unit
  input wire logic shift_clk,
  input wire logic tx_frame_sync_n,
  // toward the unit
  output logic serial_out
);
  logic [15:0] word_q[$];
  logic [13:0] exp_q[$];
  logic [15:0] cur = 16'h0000;
  logic [15:0] last_pri = 16'h0000;
  logic sec_next = 1'b0;
  int bit_n = 17;
  initial serial_out = 1'b0;
  task automatic push(input logic [15:0] w);
    word_q.push_back(w);
  endtask
  // data moves on shift rise; released line toggles every shift clock
  always @(posedge shift_clk) begin
    #1;
    if (tx_frame_sync_n) begin
      bit_n = 17;
      serial_out = ~serial_out;
    end else begin
      if (bit_n == 17) begin
        cur = word_q.size() > 0 ? word_q.pop_front() : {last_pri[15:2], 2'b00};
        if (!sec_next) begin
          last_pri = cur;
          exp_q.push_back(cur[15:2]);
        end
        sec_next = !sec_next && cur[1:0] == 2'b11;
        bit_n = 0;
      end
      serial_out = bit_n < 16 ? cur[15 - bit_n] : ~serial_out;
      bit_n = bit_n < 16 ? bit_n + 1 : 16;
    end
  end
endmodule
